/* File: shared/sles_pkg.sv */
// shared constants and types for the stream link error status block
package sles_pkg;

  // register word indices; byte address is four times the index
  localparam logic [9:0] TX_FLAGS_IDX   = 10'h090;
  localparam logic [9:0] TX_MASK_IDX    = 10'h091;
  localparam logic [9:0] TX_MODE_IDX    = 10'h092;
  localparam logic [9:0] RX_CTRL_IDX    = 10'h0C2;
  localparam logic [9:0] RX_FLAGS_IDX   = 10'h0D0;
  localparam logic [9:0] RX_MASK_IDX    = 10'h0D1;
  localparam logic [9:0] RX_META_IDX    = 10'h0D2;
  localparam int         ADDR_W         = 12;
  localparam int         IDX_LSB        = 2;

  // transmit status field positions
  localparam int TX_PHY_OVF_BIT   = 0;
  localparam int TX_PHY_UNF_BIT   = 1;
  localparam int TX_SYNC_LOST_BIT = 2;
  localparam int TX_ADAPT_OVF_BIT = 3;
  localparam int TX_ECC_CORR_BIT  = 4;
  localparam int TX_ECC_FATAL_BIT = 5;
  localparam int TX_GAP_ERR_BIT   = 6;
  localparam int TX_FLAGS_W       = 7;

  // receive status field positions
  localparam int RX_CRC_BIT       = 0;
  localparam int RX_ALIGN_BIT     = 1;
  localparam int RX_META_BIT      = 2;
  localparam int RX_FLAGS_W       = 3;

  // control field positions
  localparam int RX_REINIT_BIT    = 0;
  localparam int TX_MODE_BIT      = 0;

  // reset values
  localparam logic [6:0] TX_FLAGS_RST = 7'h00;
  localparam logic [6:0] TX_MASK_RST  = 7'h48;
  localparam logic [2:0] RX_FLAGS_RST = 3'h0;
  localparam logic [2:0] RX_MASK_RST  = 3'h0;
  localparam logic       RX_CTRL_RST  = 1'h0;
  localparam logic       TX_MODE_RST  = 1'h0;

  // operating modes of the source side
  typedef enum logic {
    SLES_MODE_CONTINUOUS,
    SLES_MODE_BURST
  } sles_mode_type;

  // gap tracker states
  typedef enum logic [1:0] {
    SLES_GAP_FIRST,
    SLES_GAP_BURST,
    SLES_GAP_IDLE
  } sles_gap_state_type;

  // apb request fields travel together
  typedef struct packed {
    logic              sel;
    logic              enable;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } sles_apb_req_type;

  // transmit side event inputs
  typedef struct packed {
    logic phy_ovf;
    logic phy_unf;
    logic sync_lost;
    logic adapt_ovf;
  } sles_tx_evt_type;

endpackage : sles_pkg

/* File: logic/sles_error_regs.sv */
// error detection, status, interrupt and control registers of the stream link
//
// The APB register port was decided locally.
`timescale 1ns/1ns
`default_nettype none

module sles_error_regs #(
  parameter int LANES     = 4,
  parameter int BURST_GAP = 2,
  parameter int GAP_W     = 8
) (
  // clock, reset, enable
  input  wire  logic                  CORE_CLK_IN,
  input  wire  logic                  SRST_IN,
  input  wire  logic                  CE_IN,
  // apb slave
  input  wire  logic                  PSEL_IN,
  input  wire  logic                  PENABLE_IN,
  input  wire  logic                  PWRITE_IN,
  input  wire  logic [11:0]           PADDR_IN,
  input  wire  logic [31:0]           PWDATA_IN,
  output logic                        PREADY_OUT,
  output logic                        PSLVERR_OUT,
  output logic [31:0]                 PRDATA_OUT,
  // source side events
  input  wire  logic                  TX_ADAPT_OVF_IN,
  input  wire  logic                  TX_VALID_IN,
  input  wire  logic                  TX_PHY_OVF_IN,
  input  wire  logic                  TX_PHY_UNF_IN,
  input  wire  logic                  TX_SYNC_LOST_IN,
  input  wire  logic [LANES-1:0]      TX_ECC_CORR_IN,
  input  wire  logic [LANES-1:0]      TX_ECC_FATAL_IN,
  // sink side events
  input  wire  logic [LANES-1:0]      RX_CRC_ERR_IN,
  input  wire  logic                  RX_ALIGN_LOST_IN,
  input  wire  logic                  RX_META_ERR_IN,
  input  wire  logic                  RX_META_END_IN,
  // error indications
  output logic                        TX_ERROR_OUT,
  output logic [LANES:0]              RX_ERROR_OUT,
  output logic                        RX_META_ERR_OUT,
  output logic                        RX_LINK_REINIT_OUT,
  // interrupts
  output logic                        TX_IRQ_OUT,
  output logic                        RX_IRQ_OUT
);

  sles_pkg::sles_apb_req_type  req;
  sles_pkg::sles_tx_evt_type   tx_evt;
  sles_pkg::sles_mode_type     tx_mode;
  sles_pkg::sles_gap_state_type gap_state;
  logic [9:0]                  idx;
  logic                        acc;
  logic                        wr_acc;
  logic                        rd_acc;
  logic                        mapped;
  logic [31:0]                 next_rdata;
  logic [sles_pkg::TX_FLAGS_W-1:0] tx_flags;
  logic [sles_pkg::TX_FLAGS_W-1:0] tx_mask;
  logic [sles_pkg::TX_FLAGS_W-1:0] tx_set;
  logic [sles_pkg::TX_FLAGS_W-1:0] tx_clr;
  logic [sles_pkg::RX_FLAGS_W-1:0] rx_flags;
  logic [sles_pkg::RX_FLAGS_W-1:0] rx_mask;
  logic [sles_pkg::RX_FLAGS_W-1:0] rx_set;
  logic [sles_pkg::RX_FLAGS_W-1:0] rx_clr;
  logic                        rx_ctrl;
  logic                        adapt_hit;
  logic                        gap_short;
  logic [GAP_W-1:0]            gap_cnt;
  logic [LANES:0]              next_rx_error;
  logic [LANES:0]              rx_evt_vec;

  // bundle the bus request so decode reads one carrier
  assign req.sel    = PSEL_IN;
  assign req.enable = PENABLE_IN;
  assign req.write  = PWRITE_IN;
  assign req.addr   = PADDR_IN;
  assign req.wdata  = PWDATA_IN;

  assign tx_evt.phy_ovf   = TX_PHY_OVF_IN;
  assign tx_evt.phy_unf   = TX_PHY_UNF_IN;
  assign tx_evt.sync_lost = TX_SYNC_LOST_IN;
  assign tx_evt.adapt_ovf = TX_ADAPT_OVF_IN;

  // decode: zero wait states, so every access completes in its first cycle
  // clock enable gates the access, so a frozen bank changes nothing
  assign idx    = req.addr[sles_pkg::ADDR_W-1:sles_pkg::IDX_LSB];
  assign acc    = req.sel && req.enable && CE_IN;
  assign wr_acc = acc && req.write;
  assign rd_acc = acc && !req.write;

  // register map decode
  always_comb
  begin
    mapped     = 1'b1;
    next_rdata = 32'h0000_0000;
    case (idx)
      sles_pkg::TX_FLAGS_IDX: next_rdata[sles_pkg::TX_FLAGS_W-1:0] = tx_flags;
      sles_pkg::TX_MASK_IDX:  next_rdata[sles_pkg::TX_FLAGS_W-1:0] = tx_mask;
      sles_pkg::TX_MODE_IDX:  next_rdata[sles_pkg::TX_MODE_BIT]    = tx_mode;
      sles_pkg::RX_CTRL_IDX:  next_rdata[sles_pkg::RX_REINIT_BIT]  = rx_ctrl;
      sles_pkg::RX_FLAGS_IDX: next_rdata[sles_pkg::RX_FLAGS_W-1:0] = rx_flags;
      sles_pkg::RX_MASK_IDX:  next_rdata[sles_pkg::RX_FLAGS_W-1:0] = rx_mask;
      sles_pkg::RX_META_IDX:  next_rdata[0]                        = RX_META_ERR_OUT;
      default:                mapped = 1'b0;
    endcase
  end

  // handshake is combinational; error only for unmapped words
  // tying ready high means this bank can never stall a master
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = req.sel && req.enable && !mapped;

  // read data is registered during setup so it is stable in the access cycle
  // the read clear reuses this word, so a late event is not lost
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      PRDATA_OUT <= 32'h0000_0000;
    else if (CE_IN && req.sel && !req.enable)
      PRDATA_OUT <= next_rdata;
  end

  // overflow qualified by mode; burst mode ignores overflow between bursts
  // valid is the only view of burst state this bank gets
  always_comb
  begin
    adapt_hit = 1'b0;
    case (tx_mode)
      sles_pkg::SLES_MODE_CONTINUOUS: adapt_hit = tx_evt.adapt_ovf;
      sles_pkg::SLES_MODE_BURST:      adapt_hit = tx_evt.adapt_ovf && TX_VALID_IN;
      default:                        adapt_hit = 1'b0;
    endcase
  end

  // source error flag: registered, so it follows the qualified overflow one cycle later for as long as it lasts
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      TX_ERROR_OUT <= 1'b0;
    else if (CE_IN)
      TX_ERROR_OUT <= adapt_hit;
  end

  // burst gap tracker: counts idle cycles between valid stretches
  // the first burst after reset has nothing before it, so it never flags
  // counting stops at the limit, so any longer gap looks the same
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      gap_state <= sles_pkg::SLES_GAP_FIRST;
      gap_cnt   <= '0;
    end
    else if (CE_IN)
    begin
      case (gap_state)
        sles_pkg::SLES_GAP_FIRST:
          if (TX_VALID_IN)
            gap_state <= sles_pkg::SLES_GAP_BURST;
        sles_pkg::SLES_GAP_BURST:
          if (!TX_VALID_IN)
          begin
            gap_state <= sles_pkg::SLES_GAP_IDLE;
            gap_cnt   <= GAP_W'(1);
          end
        sles_pkg::SLES_GAP_IDLE:
          if (TX_VALID_IN)
            gap_state <= sles_pkg::SLES_GAP_BURST;
          else if (gap_cnt < GAP_W'(BURST_GAP))
            gap_cnt <= gap_cnt + GAP_W'(1); // saturates at the limit, no wrap
        default:
          gap_state <= sles_pkg::SLES_GAP_FIRST;
      endcase
    end
  end

  // a new burst that starts before the gap is long enough
  assign gap_short = (gap_state == sles_pkg::SLES_GAP_IDLE) && TX_VALID_IN &&
                     (gap_cnt < GAP_W'(BURST_GAP));

  // transmit status set sources, lanes folded into one bit each
  // which lane hit an ecc error is lost here; only the fold is kept
  always_comb
  begin
    tx_set                             = '0;
    tx_set[sles_pkg::TX_PHY_OVF_BIT]   = tx_evt.phy_ovf;
    tx_set[sles_pkg::TX_PHY_UNF_BIT]   = tx_evt.phy_unf;
    tx_set[sles_pkg::TX_SYNC_LOST_BIT] = tx_evt.sync_lost;
    tx_set[sles_pkg::TX_ADAPT_OVF_BIT] = adapt_hit;
    tx_set[sles_pkg::TX_ECC_CORR_BIT]  = |TX_ECC_CORR_IN;
    tx_set[sles_pkg::TX_ECC_FATAL_BIT] = |TX_ECC_FATAL_IN;
    tx_set[sles_pkg::TX_GAP_ERR_BIT]   = gap_short;
  end

  // clears: a read of the status word or write-one-to-clear
  always_comb
  begin
    tx_clr = '0;
    rx_clr = '0;
    if (idx == sles_pkg::TX_FLAGS_IDX)
    begin
      // clear only what the read returned; a set since setup survives
      if (rd_acc)
        tx_clr = PRDATA_OUT[sles_pkg::TX_FLAGS_W-1:0];
      else if (wr_acc)
        tx_clr = req.wdata[sles_pkg::TX_FLAGS_W-1:0];
    end
    if (idx == sles_pkg::RX_FLAGS_IDX)
    begin
      // same rule as transmit: never drop an event the read did not show
      if (rd_acc)
        rx_clr = PRDATA_OUT[sles_pkg::RX_FLAGS_W-1:0];
      else if (wr_acc)
        rx_clr = req.wdata[sles_pkg::RX_FLAGS_W-1:0];
    end
  end

  // sticky transmit status; a set in the clearing cycle wins
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      tx_flags <= sles_pkg::TX_FLAGS_RST;
    else if (CE_IN)
      tx_flags <= (tx_flags & ~tx_clr) | tx_set;
  end

  // transmit interrupt enables, gap and overflow on after reset
  // enabling over a pending bit raises the interrupt at once
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      tx_mask <= sles_pkg::TX_MASK_RST;
    else if (wr_acc && idx == sles_pkg::TX_MASK_IDX)
      tx_mask <= req.wdata[sles_pkg::TX_FLAGS_W-1:0];
  end

  // source operating mode selection
  // a change mid-burst acts from the next cycle on
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      tx_mode <= sles_pkg::sles_mode_type'(sles_pkg::TX_MODE_RST);
    else if (wr_acc && idx == sles_pkg::TX_MODE_IDX)
      tx_mode <= sles_pkg::sles_mode_type'(req.wdata[sles_pkg::TX_MODE_BIT]);
  end

  // sink error vector: one bit per lane plus alignment loss on top
  // not sticky; software sees the sticky copy in receive status
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      assign rx_evt_vec[g] = RX_CRC_ERR_IN[g];
    end
  endgenerate
  assign rx_evt_vec[LANES] = RX_ALIGN_LOST_IN;
  assign next_rx_error     = rx_evt_vec;

  // registered, so each event shows one cycle later for as long as it lasts
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      RX_ERROR_OUT <= '0;
    else if (CE_IN)
      RX_ERROR_OUT <= next_rx_error;
  end

  // frame error is only known at the frame's end; may lag delivered packets
  // a clean frame end drops the level again
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      RX_META_ERR_OUT <= 1'b0;
    else if (CE_IN && RX_META_END_IN)
      RX_META_ERR_OUT <= RX_META_ERR_IN;
  end

  // receive status set sources
  // a frame error counts only together with its frame end
  always_comb
  begin
    rx_set                          = '0;
    rx_set[sles_pkg::RX_CRC_BIT]    = |RX_CRC_ERR_IN;
    rx_set[sles_pkg::RX_ALIGN_BIT]  = RX_ALIGN_LOST_IN;
    rx_set[sles_pkg::RX_META_BIT]   = RX_META_END_IN && RX_META_ERR_IN;
  end

  // sticky receive status; set beats clear
  // same read-clear and write-one-clear rules as transmit
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      rx_flags <= sles_pkg::RX_FLAGS_RST;
    else if (CE_IN)
      rx_flags <= (rx_flags & ~rx_clr) | rx_set;
  end

  // receive interrupt enables
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      rx_mask <= sles_pkg::RX_MASK_RST;
    else if (wr_acc && idx == sles_pkg::RX_MASK_IDX)
      rx_mask <= req.wdata[sles_pkg::RX_FLAGS_W-1:0];
  end

  // link restart level; software writes it back to zero to release
  // not self-clearing, so alignment stays held in idle until released
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
      rx_ctrl <= sles_pkg::RX_CTRL_RST;
    else if (wr_acc && idx == sles_pkg::RX_CTRL_IDX)
      rx_ctrl <= req.wdata[sles_pkg::RX_REINIT_BIT];
  end
  assign RX_LINK_REINIT_OUT = rx_ctrl;

  // level interrupts straight from registered status and enables
  // no edge logic: the line stays up until the status bit or its enable is cleared
  assign TX_IRQ_OUT = |(tx_flags & tx_mask);
  assign RX_IRQ_OUT = |(rx_flags & rx_mask);

endmodule : sles_error_regs

`default_nettype wire

/* File: testbench/sles_link_model.sv */
// far-end link model: lane error events and meta-frame framing
`timescale 1ns/1ns
`default_nettype none
module sles_link_model #(
  parameter int LANES = 4,
  parameter int FRAME = 8
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // requests from the bench
  input  wire logic [LANES-1:0] crc_req_in,
  input  wire logic             align_req_in,
  input  wire logic             err_req_in,
  // events toward the sink
  output logic      [LANES-1:0] crc_out,
  output logic                  align_out,
  output logic                  meta_err_out,
  output logic                  meta_end_out
);
  logic [7:0] cnt;
  // framing runs free; the error line is only meaningful at frame end,
  // so between ends it toggles to expose a sink that samples too early
  // packet checksums belong to the user payload, not modelled here
  always_ff @(posedge clk_in)
  begin
    cnt <= (rst_in || cnt == 8'(FRAME - 1)) ? 8'h00 : cnt + 8'h01;
    meta_end_out <= !rst_in && cnt == 8'(FRAME - 1);
    meta_err_out <= (cnt == 8'(FRAME - 1)) ? err_req_in : !meta_err_out;
    crc_out <= rst_in ? '0 : crc_req_in;
    align_out <= !rst_in && align_req_in;
  end
endmodule : sles_link_model
`default_nettype wire

/* File: testbench/sles_chk.sv */
// concurrent checks on the error register block ports
`timescale 1ns/1ns
`default_nettype none
module sles_chk #(
  parameter int LANES = 4
) (
  // clock, reset and bus
  input wire logic             CORE_CLK_IN,
  input wire logic             SRST_IN,
  input wire logic             CE_IN,
  input wire logic             PSEL_IN,
  input wire logic             PENABLE_IN,
  input wire logic             PWRITE_IN,
  input wire logic [11:0]      PADDR_IN,
  input wire logic [31:0]      PWDATA_IN,
  input wire logic             PSLVERR_OUT,
  // events and indications
  input wire logic             TX_ADAPT_OVF_IN,
  input wire logic [LANES-1:0] RX_CRC_ERR_IN,
  input wire logic             RX_ALIGN_LOST_IN,
  input wire logic             RX_META_ERR_IN,
  input wire logic             RX_META_END_IN,
  input wire logic             TX_ERROR_OUT,
  input wire logic [LANES:0]   RX_ERROR_OUT,
  input wire logic             RX_META_ERR_OUT,
  input wire logic             RX_LINK_REINIT_OUT,
  input wire logic             TX_IRQ_OUT,
  input wire logic             RX_IRQ_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (SRST_IN);
  // access qualifiers
  wire       acc = PSEL_IN && PENABLE_IN && CE_IN;
  wire [9:0] ix  = PADDR_IN[11:2];
  wire       hit = ix inside {sles_pkg::TX_FLAGS_IDX, sles_pkg::TX_MASK_IDX,
    sles_pkg::TX_MODE_IDX, sles_pkg::RX_CTRL_IDX, sles_pkg::RX_FLAGS_IDX,
    sles_pkg::RX_MASK_IDX, sles_pkg::RX_META_IDX};
  tx_pulse_a: assert property (TX_ERROR_OUT && $past(CE_IN) |-> $past(TX_ADAPT_OVF_IN))
    else $error("tx error without overflow");
  crc_lane_a: assert property (CE_IN |=> RX_ERROR_OUT[LANES-1:0] == $past(RX_CRC_ERR_IN))
    else $error("lane error bits wrong");
  align_bit_a: assert property (CE_IN |=> RX_ERROR_OUT[LANES] == $past(RX_ALIGN_LOST_IN))
    else $error("alignment error bit wrong");
  meta_load_a: assert property (RX_META_END_IN && CE_IN |=> RX_META_ERR_OUT == $past(RX_META_ERR_IN))
    else $error("meta error not loaded");
  meta_hold_a: assert property (!(RX_META_END_IN && CE_IN) |=> $stable(RX_META_ERR_OUT))
    else $error("meta error moved mid frame");
  decode_ok_a: assert property (acc |-> PSLVERR_OUT == !hit)
    else $error("address decode wrong");
  reinit_wr_a: assert property (acc && PWRITE_IN && ix == sles_pkg::RX_CTRL_IDX
    |=> RX_LINK_REINIT_OUT == $past(PWDATA_IN[0]))
    else $error("reinit level wrong");
  tx_irq_fall_a: assert property ($fell(TX_IRQ_OUT) && !$past(SRST_IN) |-> $past(acc))
    else $error("tx irq dropped without access");
  rx_irq_fall_a: assert property ($fell(RX_IRQ_OUT) && !$past(SRST_IN) |-> $past(acc))
    else $error("rx irq dropped without access");
  // main scenarios reached
  cover property (TX_ERROR_OUT);
  cover property (RX_ERROR_OUT[LANES]);
  cover property (acc && !hit);
endmodule : sles_chk
bind sles_error_regs sles_chk #(.LANES(LANES)) chk (.CORE_CLK_IN(CORE_CLK_IN),
  .SRST_IN(SRST_IN), .CE_IN(CE_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PSLVERR_OUT(PSLVERR_OUT), .TX_ADAPT_OVF_IN(TX_ADAPT_OVF_IN),
  .RX_CRC_ERR_IN(RX_CRC_ERR_IN), .RX_ALIGN_LOST_IN(RX_ALIGN_LOST_IN),
  .RX_META_ERR_IN(RX_META_ERR_IN), .RX_META_END_IN(RX_META_END_IN),
  .TX_ERROR_OUT(TX_ERROR_OUT), .RX_ERROR_OUT(RX_ERROR_OUT),
  .RX_META_ERR_OUT(RX_META_ERR_OUT), .RX_LINK_REINIT_OUT(RX_LINK_REINIT_OUT),
  .TX_IRQ_OUT(TX_IRQ_OUT), .RX_IRQ_OUT(RX_IRQ_OUT));
`default_nettype wire

/* File: testbench/stream_link_error_status_tb_top.sv */
// self-checking bench for the stream link error register block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module stream_link_error_status_tb_top;
  localparam int FRAME = 8;
  logic clk = 1'b0, rst = 1'b1, ovf = 1'b0, vld = 1'b0, pov = 1'b0, pun = 1'b0;
  logic slost = 1'b0, alq = 1'b0, erq = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ce = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwd = 32'h0, q, r, prd;
  logic [3:0]  ecor = 4'h0, efat = 4'h0, crcq = 4'h0, lcrc;
  logic [4:0]  rxe;
  logic        slv, rdy, err, lal, mer, mend, txe, mout, reinit, txirq, rxirq;
  int          fails = 0, comparisons = 0, seed = 32'h8F3A147A;
  // 10 MHz core clock
  always #50 clk = ~clk;
  sles_link_model #(.LANES(4), .FRAME(FRAME)) M (.clk_in(clk), .rst_in(rst),
    .crc_req_in(crcq), .align_req_in(alq), .err_req_in(erq), .crc_out(lcrc),
    .align_out(lal), .meta_err_out(mer), .meta_end_out(mend));
  sles_error_regs #(.LANES(4), .BURST_GAP(2)) DUT (.CORE_CLK_IN(clk), .SRST_IN(rst),
    .CE_IN(ce), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwd), .PREADY_OUT(rdy), .PSLVERR_OUT(err), .PRDATA_OUT(prd),
    .TX_ADAPT_OVF_IN(ovf), .TX_VALID_IN(vld), .TX_PHY_OVF_IN(pov), .TX_PHY_UNF_IN(pun),
    .TX_SYNC_LOST_IN(slost), .TX_ECC_CORR_IN(ecor), .TX_ECC_FATAL_IN(efat),
    .RX_CRC_ERR_IN(lcrc), .RX_ALIGN_LOST_IN(lal), .RX_META_ERR_IN(mer),
    .RX_META_END_IN(mend), .TX_ERROR_OUT(txe), .RX_ERROR_OUT(rxe),
    .RX_META_ERR_OUT(mout), .RX_LINK_REINIT_OUT(reinit), .TX_IRQ_OUT(txirq),
    .RX_IRQ_OUT(rxirq));
  // expected status words
  function automatic logic [31:0] tx_exp(input logic [10:0] v);
    return {26'h0, |v[7:4], |v[3:0], 1'b0, v[10:8]};
  endfunction : tx_exp
  function automatic logic [31:0] rx_exp(input logic [3:0] c, input logic a, input logic m);
    return {29'h0, m, a, |c};
  endfunction : rx_exp
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [9:0] ix, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {ix, 2'h0};
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    q = prd;
    slv = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [9:0] ix, input logic [31:0] e, input string n);
    apb(1'b0, ix, 32'h0);
    `CHK(n, e, q)
  endtask : rdchk
  // one-cycle overflow; e is the expected error flag, checked where it settles
  task automatic pulse_ovf(input logic e);
    @(posedge clk);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    @(negedge clk);
    `CHK("txerr", e, txe)
    @(negedge clk);
    `CHK("txpulse", 1'b0, txe)
    @(posedge clk);
  endtask : pulse_ovf
  // two valid stretches separated by n idle cycles
  task automatic gap(input int n);
    @(posedge clk);
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    repeat (n) @(posedge clk);
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
  endtask : gap
  task automatic wrap_up();
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdchk(sles_pkg::TX_MASK_IDX, 32'h48, "txmask");
    rdchk(sles_pkg::TX_FLAGS_IDX, 32'h0, "txflags");
    rdchk(sles_pkg::RX_CTRL_IDX, 32'h0, "rxctrl");
    rdchk(10'h0A0, 32'h0, "unmapped");
    `CHK("slverr", 1'b1, slv)
    // clock enable low: bus write and overflow must leave no trace
    ce <= 1'b0;
    apb(1'b1, sles_pkg::TX_MASK_IDX, 32'h0);
    pulse_ovf(1'b0);
    ce <= 1'b1;
    rdchk(sles_pkg::TX_FLAGS_IDX, 32'h0, "frozen");
    rdchk(sles_pkg::TX_MASK_IDX, 32'h48, "maskkept");
    pulse_ovf(1'b1);
    @(posedge clk);
    `CHK("txirq", 1'b1, txirq)
    rdchk(sles_pkg::TX_FLAGS_IDX, 32'h08, "txovf");
    pulse_ovf(1'b1);
    apb(1'b1, sles_pkg::TX_FLAGS_IDX, 32'h0);
    rdchk(sles_pkg::TX_FLAGS_IDX, 32'h08, "w1czero");
    pulse_ovf(1'b1);
    apb(1'b1, sles_pkg::TX_FLAGS_IDX, 32'h08);
    rdchk(sles_pkg::TX_FLAGS_IDX, 32'h0, "w1cone");
    apb(1'b1, sles_pkg::TX_MASK_IDX, 32'h0);
    pulse_ovf(1'b1);
    @(posedge clk);
    `CHK("masked", 1'b0, txirq)
    apb(1'b1, sles_pkg::TX_MASK_IDX, 32'h48);
    @(posedge clk);
    `CHK("unmasked", 1'b1, txirq)
    rdchk(sles_pkg::TX_FLAGS_IDX, 32'h08, "maskovf");
    apb(1'b1, sles_pkg::TX_MODE_IDX, 32'h1);
    rdchk(sles_pkg::TX_MODE_IDX, 32'h1, "moderd");
    pulse_ovf(1'b0);
    rdchk(sles_pkg::TX_FLAGS_IDX, 32'h0, "burstidle");
    vld <= 1'b1;
    pulse_ovf(1'b1);
    vld <= 1'b0;
    rdchk(sles_pkg::TX_FLAGS_IDX, 32'h08, "burstovf");
    gap(1);
    rdchk(sles_pkg::TX_FLAGS_IDX, 32'h40, "gapshort");
    gap(2);
    rdchk(sles_pkg::TX_FLAGS_IDX, 32'h0, "gapmin");
    for (int i = 0; i < 5; i++)
    begin
      r = (i == 0) ? 32'h7FF : $random(seed);
      @(posedge clk);
      ecor <= r[3:0];
      efat <= r[7:4];
      {slost, pun, pov} <= r[10:8];
      @(posedge clk);
      ecor <= 4'h0;
      efat <= 4'h0;
      {slost, pun, pov} <= 3'h0;
      rdchk(sles_pkg::TX_FLAGS_IDX, tx_exp(r[10:0]), "txevt");
    end
    apb(1'b1, sles_pkg::RX_MASK_IDX, 32'h7);
    for (int i = 0; i < 5; i++)
    begin
      r = (i == 0) ? 32'h1F : $random(seed);
      @(posedge clk);
      crcq <= r[3:0];
      alq <= r[4];
      @(posedge clk);
      crcq <= 4'h0;
      alq <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      `CHK("rxerr", r[4:0], rxe)
      @(posedge clk);
      `CHK("rxirq", |r[4:0], rxirq)
      @(negedge clk);
      `CHK("rxpulse", 5'h00, rxe)
      rdchk(sles_pkg::RX_FLAGS_IDX, rx_exp(r[3:0], r[4], 1'b0), "rxevt");
    end
    erq <= 1'b1;
    repeat (FRAME + 2) @(posedge clk);
    `CHK("metaset", 1'b1, mout)
    rdchk(sles_pkg::RX_META_IDX, 32'h1, "metard");
    erq <= 1'b0;
    rdchk(sles_pkg::RX_FLAGS_IDX, rx_exp(4'h0, 1'b0, 1'b1), "metaflag");
    repeat (FRAME + 2) @(posedge clk);
    `CHK("metaclr", 1'b0, mout)
    apb(1'b1, sles_pkg::RX_CTRL_IDX, 32'h1);
    @(posedge clk);
    `CHK("reinit", 1'b1, reinit)
    rdchk(sles_pkg::RX_CTRL_IDX, 32'h1, "rxctrlrd");
    wrap_up();
  end
  // watchdog: the sequence needs well under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    wrap_up();
  end
endmodule : stream_link_error_status_tb_top
`default_nettype wire
